// ===== pkg/core_state_pkg.sv
// Contract
// - One 64 KB space, I/O lowest, data above.
// - Instruction pointer is 16 bits wide.
// - Accumulator 16 bits; byte ops use low byte.
// - Extra, index and stack pointers 16 bits.
// - Status word: bank select high, flags low.
// - Half-carry from carry/borrow bit 3 to 4.
// - Interrupt enable gates interrupts, reset clears.
// - Request served only if outranking level; 3 none.
// - Negative flag copies result MSB.
// - Zero flag set on zero result.
// - Overflow flag on two's-complement overflow.
// - Carry flag on carry/borrow out of bit 7.
// - Shifts put shifted-out bit in carry.
// - Eight 8-bit registers per memory bank.
// - Up to thirty-two selectable register banks.
package core_state_pkg;

    // ------------------------------------------------------------
    // Bus widths and answers
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    typedef logic [ADDR_W-1:0] axi_addr_t;
    typedef logic [31:0]       axi_data_t;
    typedef logic [3:0]        axi_strb_t;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam axi_addr_t OFF_IP       = 8'h00;
    localparam axi_addr_t OFF_ACC      = 8'h04;
    localparam axi_addr_t OFF_TMP      = 8'h08;
    localparam axi_addr_t OFF_IX       = 8'h0c;
    localparam axi_addr_t OFF_EP       = 8'h10;
    localparam axi_addr_t OFF_SP       = 8'h14;
    localparam axi_addr_t OFF_PSW      = 8'h18;
    localparam axi_addr_t OFF_ALU_CMD  = 8'h1c;
    localparam axi_addr_t OFF_GPR_SEL  = 8'h20;
    localparam axi_addr_t OFF_IRQ_STAT = 8'h24;
    localparam axi_addr_t OFF_PROBE    = 8'h28;

    // ------------------------------------------------------------
    // Memory map of the unified space
    // ------------------------------------------------------------
    localparam logic [16:0] MEM_SPACE_BYTES = 17'h10000;
    localparam logic [15:0] DATA_BASE       = 16'h0080;
    localparam logic [15:0] PROGRAM_BASE    = 16'h8000;
    localparam logic [15:0] GPR_BASE        = 16'h0100;
    localparam logic [15:0] IP_STEP         = 16'h0001;
    localparam int          GPR_PER_BANK    = 8;
    localparam int          BANK_COUNT      = 32;

    typedef enum logic [1:0] {
        REGION_IO      = 2'b00,
        REGION_DATA    = 2'b01,
        REGION_PROGRAM = 2'b10
    } region_t;

    // ------------------------------------------------------------
    // Condition flags and status word
    // ------------------------------------------------------------
    typedef struct packed {
        logic       h;
        logic       i;
        logic [1:0] il;
        logic       n;
        logic       z;
        logic       v;
        logic       c;
    } condition_flags_t;

    localparam logic [1:0]  IL_NONE    = 2'h3;
    localparam logic [15:0] PSW_RESET  = 16'h0030;
    localparam int          BANK_LSB   = 11;

    // ------------------------------------------------------------
    // Byte arithmetic unit
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_ADD  = 4'b0000,
        OP_SUB  = 4'b0001,
        OP_ADDC = 4'b0010,
        OP_SUBC = 4'b0011,
        OP_SHL  = 4'b0100,
        OP_SHR  = 4'b0101,
        OP_AND  = 4'b0110,
        OP_OR   = 4'b0111,
        OP_XOR  = 4'b1000
    } alu_op_t;

    typedef struct packed {
        logic [7:0] value;
        logic       h;
        logic       n;
        logic       z;
        logic       v;
        logic       c;
        logic       upd_h;
        logic       upd_v;
        logic       upd_c;
    } alu_result_t;

endpackage : core_state_pkg

// ===== rtl/byte_alu.sv
`timescale 1ns/1ps
`default_nettype none
module byte_alu (
    // Operation and operands
    input  wire core_state_pkg::alu_op_t     op,
    input  wire logic [7:0]                  a,
    input  wire logic [7:0]                  b,
    input  wire logic                        cin,
    // Result and flags
    output core_state_pkg::alu_result_t      res
);
    import core_state_pkg::*;

    logic [8:0] wide;

    // --------------------------------------------------------------
    // Operation select
    // --------------------------------------------------------------
    // Subtraction keeps the ninth bit as the borrow, so one formula
    // covers carry and borrow out of bit 7.
    always_comb begin
        wide      = 9'h000;
        res       = '0;
        case (op)
            OP_ADD, OP_ADDC: begin
                wide = {1'b0, a} + {1'b0, b}
                     + {8'h00, (op == OP_ADDC) & cin};
                res.upd_h = 1'b1;
                res.upd_v = 1'b1;
                res.upd_c = 1'b1;
                res.v = (a[7] == b[7]) && (wide[7] != a[7]);
            end
            OP_SUB, OP_SUBC: begin
                wide = {1'b0, a} - {1'b0, b}
                     - {8'h00, (op == OP_SUBC) & cin};
                res.upd_h = 1'b1;
                res.upd_v = 1'b1;
                res.upd_c = 1'b1;
                res.v = (a[7] != b[7]) && (wide[7] != a[7]);
            end
            OP_SHL: begin
                wide = {a[7], a[6:0], cin};
                res.upd_c = 1'b1;
            end
            OP_SHR: begin
                wide = {a[0], cin, a[7:1]};
                res.upd_c = 1'b1;
            end
            OP_AND: begin
                wide = {1'b0, a & b};
                res.upd_v = 1'b1;
            end
            OP_OR: begin
                wide = {1'b0, a | b};
                res.upd_v = 1'b1;
            end
            OP_XOR: begin
                wide = {1'b0, a ^ b};
                res.upd_v = 1'b1;
            end
            default: begin
                wide = {1'b0, a};
            end
        endcase
        res.value = wide[7:0];
        res.c     = wide[8];
        res.h     = a[4] ^ b[4] ^ wide[4];
        res.n     = wide[7];
        res.z     = (wide[7:0] == 8'h00);
    end

endmodule : byte_alu
`default_nettype wire

// ===== rtl/core_state.sv
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module core_state (
    // Clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    // AXI4-Lite write channels
    input  wire logic                        s_awvalid,
    output logic                             s_awready,
    input  wire core_state_pkg::axi_addr_t   s_awaddr,
    input  wire logic                        s_wvalid,
    output logic                             s_wready,
    input  wire core_state_pkg::axi_data_t   s_wdata,
    input  wire core_state_pkg::axi_strb_t   s_wstrb,
    output logic                             s_bvalid,
    input  wire logic                        s_bready,
    output logic [1:0]                       s_bresp,
    // AXI4-Lite read channels
    input  wire logic                        s_arvalid,
    output logic                             s_arready,
    input  wire core_state_pkg::axi_addr_t   s_araddr,
    output logic                             s_rvalid,
    input  wire logic                        s_rready,
    output core_state_pkg::axi_data_t        s_rdata,
    output logic [1:0]                       s_rresp,
    // Fetch and interrupt request
    input  wire logic                        fetch_advance,
    input  wire logic                        irq_request,
    input  wire logic [1:0]                  irq_request_level,
    output logic                             irq_accept,
    // Architectural state
    output logic [15:0]                      instruction_pointer,
    output logic [15:0]                      program_status_word,
    output logic [15:0]                      gpr_phys_addr
);
    import core_state_pkg::*;

    // --------------------------------------------------------------
    // State registers
    // --------------------------------------------------------------
    logic [15:0] ip_q, acc_q, tmp_q, ix_q, ep_q, sp_q, psw_q, probe_q;
    logic [15:0] ip_d, acc_d, tmp_d, ix_d, ep_d, sp_d, psw_d, probe_d;
    logic [2:0]  gpr_sel_q, gpr_sel_d;
    logic        aw_held_q, w_held_q, bvalid_q, rvalid_q;
    axi_addr_t   awaddr_q;
    axi_data_t   wdata_q, rdata_q;
    axi_strb_t   wstrb_q;
    logic [1:0]  bresp_q, rresp_q;

    // Merges the low two byte lanes of a write into a 16-bit register.
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input axi_data_t  d,
                                            input axi_strb_t  s);
        logic [15:0] m;
        m = old;
        if (s[0]) begin
            m[7:0] = d[7:0];
        end
        if (s[1]) begin
            m[15:8] = d[15:8];
        end
        return m;
    endfunction : merge16

    // --------------------------------------------------------------
    // Write path
    // --------------------------------------------------------------
    // Address and data are caught separately so they may come in
    // either order; the write happens once both are in hand.
    wire       aw_hs   = s_awvalid & s_awready;
    wire       w_hs    = s_wvalid & s_wready;
    wire       wr_go   = (aw_held_q | aw_hs) & (w_held_q | w_hs) & ~bvalid_q;
    wire axi_addr_t wa = aw_held_q ? awaddr_q : s_awaddr;
    wire axi_data_t wd = w_held_q ? wdata_q : s_wdata;
    wire axi_strb_t ws = w_held_q ? wstrb_q : s_wstrb;

    assign s_awready = ~aw_held_q & ~bvalid_q;
    assign s_wready  = ~w_held_q & ~bvalid_q;

    // Write decode, one strobe per register except the interrupt status.
    wire wr_ip    = wr_go & (wa == OFF_IP);
    wire wr_acc   = wr_go & (wa == OFF_ACC);
    wire wr_tmp   = wr_go & (wa == OFF_TMP);
    wire wr_ix    = wr_go & (wa == OFF_IX);
    wire wr_ep    = wr_go & (wa == OFF_EP);
    wire wr_sp    = wr_go & (wa == OFF_SP);
    wire wr_psw   = wr_go & (wa == OFF_PSW);
    wire wr_gpr   = wr_go & (wa == OFF_GPR_SEL) & ws[0];
    wire wr_probe = wr_go & (wa == OFF_PROBE);
    wire alu_go   = wr_go & (wa == OFF_ALU_CMD) & ws[0];
    wire wr_known = wr_ip | wr_acc | wr_tmp | wr_ix | wr_ep | wr_sp
                  | wr_psw | (wr_go & (wa == OFF_GPR_SEL))
                  | (wr_go & (wa == OFF_ALU_CMD))
                  | (wr_go & (wa == OFF_IRQ_STAT)) | wr_probe;

    // --------------------------------------------------------------
    // Byte arithmetic on the accumulator's low byte
    // --------------------------------------------------------------
    condition_flags_t flags, alu_flags;
    alu_op_t          alu_op;
    alu_result_t      alu_res;

    assign flags  = condition_flags_t'(psw_q[7:0]);
    assign alu_op = alu_op_t'(wd[3:0]);

    // Only the low bytes of the accumulator and temporary enter.
    byte_alu u_alu (
        .op  (alu_op),
        .a   (acc_q[7:0]),
        .b   (tmp_q[7:0]),
        .cin (flags.c),
        .res (alu_res)
    );

    // Flags the operation does not define are left as they were.
    always_comb begin
        alu_flags   = flags;
        alu_flags.n = alu_res.n;
        alu_flags.z = alu_res.z;
        if (alu_res.upd_h) begin
            alu_flags.h = alu_res.h;
        end
        if (alu_res.upd_v) begin
            alu_flags.v = alu_res.v;
        end
        if (alu_res.upd_c) begin
            alu_flags.c = alu_res.c;
        end
    end

    // --------------------------------------------------------------
    // Next-state selection
    // --------------------------------------------------------------
    // A software write to the pointer wins over the fetch step.
    assign ip_d  = wr_ip ? merge16(ip_q, wd, ws)
                 : fetch_advance ? 16'(ip_q + IP_STEP) : ip_q;
    assign acc_d = wr_acc ? merge16(acc_q, wd, ws)
                 : alu_go ? {acc_q[15:8], alu_res.value} : acc_q;
    assign tmp_d = wr_tmp ? merge16(tmp_q, wd, ws) : tmp_q;
    assign ix_d  = wr_ix  ? merge16(ix_q, wd, ws) : ix_q;
    assign ep_d  = wr_ep  ? merge16(ep_q, wd, ws) : ep_q;
    assign sp_d  = wr_sp  ? merge16(sp_q, wd, ws) : sp_q;
    assign psw_d = wr_psw ? merge16(psw_q, wd, ws)
                 : alu_go ? {psw_q[15:8], alu_flags} : psw_q;
    assign gpr_sel_d = wr_gpr ? wd[2:0] : gpr_sel_q;
    assign probe_d   = wr_probe ? merge16(probe_q, wd, ws) : probe_q;

    // Architectural registers; the interrupt enable starts cleared.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ip_q      <= 16'h0000;
            acc_q     <= 16'h0000;
            tmp_q     <= 16'h0000;
            ix_q      <= 16'h0000;
            ep_q      <= 16'h0000;
            sp_q      <= 16'h0000;
            psw_q     <= PSW_RESET;
            gpr_sel_q <= 3'h0;
            probe_q   <= 16'h0000;
        end else begin
            ip_q      <= ip_d;
            acc_q     <= acc_d;
            tmp_q     <= tmp_d;
            ix_q      <= ix_d;
            ep_q      <= ep_d;
            sp_q      <= sp_d;
            psw_q     <= psw_d;
            gpr_sel_q <= gpr_sel_d;
            probe_q   <= probe_d;
        end
    end

    // Write channel holding and the write response.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            aw_held_q <= ~wr_go & (aw_held_q | aw_hs);
            w_held_q  <= ~wr_go & (w_held_q | w_hs);
            if (aw_hs) begin
                awaddr_q <= s_awaddr;
            end
            if (w_hs) begin
                wdata_q <= s_wdata;
                wstrb_q <= s_wstrb;
            end
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign s_bvalid = bvalid_q;
    assign s_bresp  = bresp_q;

    // --------------------------------------------------------------
    // Register banks, memory regions and interrupt gate
    // --------------------------------------------------------------
    // The top five bits of the bank selector pick one of 32 banks.
    wire [4:0] bank_num = psw_q[15:BANK_LSB];
    assign gpr_phys_addr = 16'(GPR_BASE + {8'h00, bank_num, 3'b000}
                         + {13'h0000, gpr_sel_q});

    // Region of the probe address within the one 64 KB space.
    wire region_t probe_region = (probe_q < DATA_BASE) ? REGION_IO
                               : (probe_q < PROGRAM_BASE) ? REGION_DATA
                               : REGION_PROGRAM;

    // Lower level numbers rank higher, so level 3 never gets in.
    assign irq_accept = irq_request & flags.i
                      & (irq_request_level < flags.il);

    // --------------------------------------------------------------
    // Read path
    // --------------------------------------------------------------
    wire rd_go = s_arvalid & s_arready;
    wire rd_known = (s_araddr == OFF_IP) | (s_araddr == OFF_ACC)
                  | (s_araddr == OFF_TMP) | (s_araddr == OFF_IX)
                  | (s_araddr == OFF_EP) | (s_araddr == OFF_SP)
                  | (s_araddr == OFF_PSW) | (s_araddr == OFF_ALU_CMD)
                  | (s_araddr == OFF_GPR_SEL) | (s_araddr == OFF_IRQ_STAT)
                  | (s_araddr == OFF_PROBE);
    wire axi_data_t rd_val =
          (s_araddr == OFF_IP)       ? {16'h0000, ip_q}
        : (s_araddr == OFF_ACC)      ? {16'h0000, acc_q}
        : (s_araddr == OFF_TMP)      ? {16'h0000, tmp_q}
        : (s_araddr == OFF_IX)       ? {16'h0000, ix_q}
        : (s_araddr == OFF_EP)       ? {16'h0000, ep_q}
        : (s_araddr == OFF_SP)       ? {16'h0000, sp_q}
        : (s_araddr == OFF_PSW)      ? {16'h0000, psw_q}
        : (s_araddr == OFF_GPR_SEL)  ? {gpr_phys_addr, 13'h0000, gpr_sel_q}
        : (s_araddr == OFF_IRQ_STAT) ? {29'h00000000, irq_accept,
                                        irq_request_level}
        : (s_araddr == OFF_PROBE)    ? {14'h0000, probe_region, probe_q}
        : 32'h00000000;

    assign s_arready = ~rvalid_q;

    // Read data is captured at the address handshake.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_val;
            rresp_q  <= rd_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_rvalid            = rvalid_q;
    assign s_rdata             = rdata_q;
    assign s_rresp             = rresp_q;
    assign instruction_pointer = ip_q;
    assign program_status_word = psw_q;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_alu(alu_op_t o);
        alu_go && (alu_op == o);
    endsequence

    ip_step_a: assert property (fetch_advance && !wr_ip |=>
        ip_q == 16'($past(ip_q) + IP_STEP))
        else $error("instruction pointer did not step");
    acc_high_a: assert property (alu_go |=>
        acc_q[15:8] == $past(acc_q[15:8]))
        else $error("accumulator high byte changed by byte op");
    bank_keep_a: assert property (alu_go |=>
        psw_q[15:8] == $past(psw_q[15:8]))
        else $error("bank selector changed by byte op");
    zero_flag_a: assert property (alu_go |=>
        flags.z == (acc_q[7:0] == 8'h00))
        else $error("zero flag does not match result");
    neg_flag_a: assert property (alu_go |=>
        flags.n == acc_q[7])
        else $error("negative flag does not match result");
    add_carry_a: assert property (s_alu(OP_ADD) |=>
        flags.c == ({1'b0, $past(acc_q[7:0])}
                  + {1'b0, $past(tmp_q[7:0])} > 9'h0ff))
        else $error("carry flag wrong after add");
    half_carry_a: assert property (s_alu(OP_ADD) |=>
        flags.h == ({1'b0, $past(acc_q[3:0])}
                  + {1'b0, $past(tmp_q[3:0])} > 5'h0f))
        else $error("half-carry flag wrong after add");
    shift_carry_a: assert property (s_alu(OP_SHL) |=>
        flags.c == $past(acc_q[7]))
        else $error("carry is not the shifted-out bit");
    irq_level_a: assert property (irq_accept |->
        irq_request_level != IL_NONE && flags.il != 2'h0)
        else $error("interrupt accepted at a blocked level");
    irq_enable_a: assert property (!flags.i |-> !irq_accept)
        else $error("interrupt accepted while disabled");
    resp_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid)
        else $error("write response dropped before ready");

endmodule : core_state
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import core_state_pkg::*;

    // ------------------------------------------------------------
    // Signals, tables and design
    // ------------------------------------------------------------
    typedef struct packed {
        alu_op_t    op;
        logic [7:0] a;
        logic [7:0] b;
        logic       ci;
        logic [7:0] r;
        logic [4:0] f;
    } row_t;
    logic        core_clk, rst, s_awvalid, s_awready, s_wvalid, s_wready;
    logic        s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid;
    logic        s_rready, fetch_advance, irq_request, irq_accept;
    logic [1:0]  s_bresp, s_rresp, irq_request_level;
    axi_addr_t   s_awaddr, s_araddr;
    axi_data_t   s_wdata, s_rdata;
    axi_strb_t   s_wstrb;
    logic [15:0] instruction_pointer, program_status_word, gpr_phys_addr;
    int          failures = 0;
    int          samples_checked = 0;
    row_t        w;
    // Operands, carry in, result and flags {h,n,z,v,c}.
    row_t        rows [13] = '{
        '{OP_ADD,  8'h08, 8'h08, 1'b0, 8'h10, 5'h10},
        '{OP_ADD,  8'h80, 8'h80, 1'b0, 8'h00, 5'h07},
        '{OP_ADD,  8'h7f, 8'h01, 1'b0, 8'h80, 5'h1a},
        '{OP_SUB,  8'h10, 8'h01, 1'b0, 8'h0f, 5'h10},
        '{OP_SUB,  8'h00, 8'h01, 1'b0, 8'hff, 5'h19},
        '{OP_ADDC, 8'hff, 8'h00, 1'b1, 8'h00, 5'h15},
        '{OP_SUBC, 8'h05, 8'h05, 1'b1, 8'hff, 5'h19},
        '{OP_SHL,  8'h81, 8'h00, 1'b0, 8'h02, 5'h01},
        '{OP_SHR,  8'h01, 8'h00, 1'b1, 8'h80, 5'h09},
        '{OP_AND,  8'hf0, 8'h0f, 1'b1, 8'h00, 5'h05},
        '{OP_OR,   8'h80, 8'h01, 1'b0, 8'h81, 5'h08},
        '{OP_XOR,  8'haa, 8'haa, 1'b0, 8'h00, 5'h04},
        '{alu_op_t'(4'hf), 8'h00, 8'h55, 1'b1, 8'h00, 5'h05}};
    axi_addr_t   ptrs [5] = '{OFF_IP, OFF_IX, OFF_EP, OFF_SP, OFF_TMP};
    // Level 3 requests never get in; a level field of 3 still admits 0.
    logic [18:0] irqs [5] = '{{16'h0060, 2'd1, 1'b1}, {16'h0060, 2'd2, 1'b0},
                              {16'h0020, 2'd0, 1'b0}, {16'h0070, 2'd0, 1'b1},
                              {16'h0070, 2'd3, 1'b0}};
    logic [17:0] prb [4] = '{{2'd0, 16'h007f}, {2'd1, 16'h0080},
                             {2'd1, 16'h7fff}, {2'd2, 16'h8000}};

    // Free-running core clock.
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    core_state dut (.core_clk, .rst, .s_awvalid, .s_awready, .s_awaddr,
        .s_wvalid, .s_wready, .s_wdata, .s_wstrb, .s_bvalid, .s_bready,
        .s_bresp, .s_arvalid, .s_arready, .s_araddr, .s_rvalid, .s_rready,
        .s_rdata, .s_rresp, .fetch_advance, .irq_request,
        .irq_request_level, .irq_accept, .instruction_pointer,
        .program_status_word, .gpr_phys_addr);

    // ------------------------------------------------------------
    // Checks and bus tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic results;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    // Handshakes are sampled at the falling edge, where inputs are still.
    task automatic wr(input axi_addr_t a, input axi_data_t d,
                      input logic [1:0] er);
        logic       ta, tw, tb;
        logic [1:0] r;
        int         n;
        @(posedge core_clk);
        {s_awvalid, s_wvalid, s_bready} <= 3'h7;
        s_awaddr <= a;
        s_wdata  <= d;
        for (n = 0; n < 40; n++) begin
            @(negedge core_clk);
            ta = s_awvalid & s_awready;
            tw = s_wvalid & s_wready;
            tb = s_bvalid;
            r  = s_bresp;
            @(posedge core_clk);
            if (ta) s_awvalid <= 1'b0;
            if (tw) s_wvalid <= 1'b0;
            if (tb) break;
        end
        s_bready <= 1'b0;
        if (n == 40) begin
            failures++;
            results;
        end
        chk({30'h0, r}, {30'h0, er});
    endtask : wr

    task automatic rd(input axi_addr_t a, input axi_data_t e,
                      input logic [1:0] er);
        logic       ta, tr;
        axi_data_t  d;
        logic [1:0] r;
        int         n;
        @(posedge core_clk);
        {s_arvalid, s_rready} <= 2'h3;
        s_araddr <= a;
        for (n = 0; n < 40; n++) begin
            @(negedge core_clk);
            ta = s_arvalid & s_arready;
            tr = s_rvalid;
            d  = s_rdata;
            r  = s_rresp;
            @(posedge core_clk);
            if (ta) s_arvalid <= 1'b0;
            if (tr) break;
        end
        s_rready <= 1'b0;
        if (n == 40) begin
            failures++;
            results;
        end
        chk(d, e);
        chk({30'h0, r}, {30'h0, er});
    endtask : rd

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst, irq_request} = 2'h3;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        {fetch_advance, irq_request_level, s_awaddr, s_araddr} = '0;
        s_wdata = '0;
        s_wstrb = 4'hf;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        chk({16'h0, program_status_word}, 32'h0030); // Reset.
        chk({31'h0, irq_accept}, 32'h0); // Blocked at reset.
        chk({16'h0, gpr_phys_addr}, 32'h0100); // Bank 0.
        // Byte operations on preset flags and a marked high byte.
        foreach (rows[k]) begin
            w = rows[k];
            wr(OFF_PSW, {31'h18, w.ci}, RESP_OKAY);
            wr(OFF_ACC, {16'h0, 8'h12, w.a}, RESP_OKAY);
            wr(OFF_TMP, {24'h0, w.b}, RESP_OKAY);
            wr(OFF_ALU_CMD, {28'h0, w.op}, RESP_OKAY);
            rd(OFF_ACC, {16'h0, 8'h12, w.r}, RESP_OKAY); // Low byte.
            chk({24'h0, program_status_word[7:0]},
            {24'h0, w.f[4], 3'b011, w.f[3:0]});
        end
        // Wide pointers and the temporary keep 16 bits, upper lanes dropped.
        foreach (ptrs[k]) begin
            wr(ptrs[k], 32'hffffa5c3, RESP_OKAY);
            rd(ptrs[k], 32'h0000a5c3, RESP_OKAY); // Width.
        end
        // Fetch across the top of the space.
        wr(OFF_IP, 32'hfffe, RESP_OKAY);
        fetch_advance <= 1'b1;
        repeat (3) @(posedge core_clk);
        fetch_advance <= 1'b0;
        @(negedge core_clk);
        chk({16'h0, instruction_pointer}, 32'h0001); // Wraps.
        // Last bank, last register.
        wr(OFF_PSW, 32'hf830, RESP_OKAY);
        wr(OFF_GPR_SEL, 32'h7, RESP_OKAY);
        rd(OFF_PSW, 32'hf830, RESP_OKAY); // Split word.
        chk({16'h0, gpr_phys_addr}, 32'h01ff); // Address.
        foreach (irqs[k]) begin
            wr(OFF_PSW, {16'h0, irqs[k][18:3]}, RESP_OKAY);
            irq_request_level <= irqs[k][2:1];
            @(negedge core_clk);
            chk({31'h0, irq_accept}, {31'h0, irqs[k][0]}); // Gate.
        end
        foreach (prb[k]) begin
            wr(OFF_PROBE, {16'h0, prb[k][15:0]}, RESP_OKAY);
            rd(OFF_PROBE, {14'h0, prb[k]}, RESP_OKAY); // Region.
        end
        // Unmapped and read-only places, then a reset in mid-run.
        wr(8'h3c, 32'h1, RESP_SLVERR);
        rd(8'h3c, 32'h0, RESP_SLVERR);
        wr(OFF_IRQ_STAT, 32'h7, RESP_OKAY);
        rst <= 1'b1;
        @(negedge core_clk);
        chk({16'h0, program_status_word}, 32'h0030); // Cleared.
        // Release on a rising edge; the bus must work from the next one.
        @(posedge core_clk);
        rst <= 1'b0;
        rd(OFF_PSW, 32'h0030, RESP_OKAY); // Still cleared.
        chk({16'h0, gpr_phys_addr}, 32'h0100); // Bank 0.
        results;
    end
endmodule : tb_top
`default_nettype wire
